/* bench/sfl_fir_monitor.sv */
// port checker for the symmetric fir filter
`timescale 1ns/1ps
module sfl_fir_monitor #(
  parameter sfl_pkg::sfl_coef_set_type COEFS = sfl_pkg::COEF_DEFAULT,
  parameter bit PIPELINED = 1'b1,
  parameter int OUT_W = sfl_pkg::ACC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // stream
  input wire logic signed [sfl_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic signed [OUT_W-1:0] result,
  input wire logic result_valid
);
  localparam int LAT = PIPELINED ? 5 : 1;
  localparam int HS = int'($signed(COEFS.h1)) + int'($signed(COEFS.h2))
    + int'($signed(COEFS.h3)) + int'($signed(COEFS.h4));
  logic signed [7:0] tap_q [8];
  logic [4:0] cnt_q;
  logic signed [17:0] ref_y;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadow tap chain, newest in slot 0
  always_ff @(posedge core_clk) begin
    tap_q[0] <= rst ? 8'sh00 : 8'(sample_in);
    for (int i = 1; i < 8; i++) begin
      tap_q[i] <= rst ? 8'sh00 : tap_q[i-1];
    end
  end
  // edges since reset release, saturating
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (cnt_q != 5'h1F) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
  function automatic logic signed [17:0] fold(logic signed [7:0] a, b, h);
    return (18'(a) + 18'(b)) * 18'(h);
  endfunction
  // mirror pairs weighted by their coefficient
  assign ref_y = fold(tap_q[0], tap_q[7], COEFS.h1) + fold(tap_q[1], tap_q[6], COEFS.h2)
    + fold(tap_q[2], tap_q[5], COEFS.h3) + fold(tap_q[3], tap_q[4], COEFS.h4);
  chk_reset_clears: assert property ($fell(rst) |-> result == '0 && !result_valid)
    else $error("result not cleared by reset");
  chk_valid_fill: assert property (result_valid == (cnt_q >= 5'(8 + LAT)))
    else $error("valid timing wrong");
  chk_valid_hold: assert property (result_valid |=> result_valid)
    else $error("valid dropped");
  chk_result_exact: assert property (result_valid |->
    result == OUT_W'($past(ref_y, LAT) >>> (18 - OUT_W)))
    else $error("result differs from tap sum");
  chk_zero_flush: assert property ((sample_in == '0) [*8] |=> ##LAT result == '0)
    else $error("zero run gives nonzero");
  chk_full_pos: assert property ((sample_in == 7'sh3F) [*8] |=> ##LAT
    result == OUT_W'((126 * HS) >>> (18 - OUT_W)))
    else $error("positive full scale wrong");
  chk_full_neg: assert property ((sample_in == 7'sh40) [*8] |=> ##LAT
    result == OUT_W'((-128 * HS) >>> (18 - OUT_W)))
    else $error("negative full scale wrong");
  chk_steady_out: assert property (result_valid && $stable(ref_y) |-> ##LAT $stable(result))
    else $error("result moved with steady taps");
endmodule
bind sfl_fir sfl_fir_monitor #(.COEFS(COEFS), .PIPELINED(PIPELINED), .OUT_W(OUT_W)) mon (
  .core_clk(core_clk), .rst(rst), .sample_in(sample_in), .result(result),
  .result_valid(result_valid));

/* bench/sfl_fir_tb.sv */
// self-checking bench for the symmetric fir filter
`timescale 1ns/1ps
module sfl_fir_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic signed [6:0] sample_in;
  logic signed [17:0] result;
  logic result_valid;
  logic signed [11:0] result_c;
  logic valid_c;
  logic signed [11:0] got_c[$];
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int lat;
  int hist[$];
  always #2 core_clk = ~core_clk;
  sfl_fir uut (.core_clk(core_clk), .rst(rst), .sample_in(sample_in), .result(result),
    .result_valid(result_valid));
  sfl_stream_partner pm (.core_clk(core_clk), .rst(rst), .sample_in(sample_in),
    .result(result), .result_valid(result_valid));
  // unpipelined narrow-output build on the same stream
  sfl_fir #(.PIPELINED(1'b0), .OUT_W(12)) uut_comb (.core_clk(core_clk), .rst(rst),
    .sample_in(sample_in), .result(result_c), .result_valid(valid_c));
  // collect every valid narrow result
  always @(posedge core_clk) begin
    if (rst) got_c = {};
    else if (valid_c) got_c.push_back(result_c);
  end
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  task automatic cmp_res(logic [17:0] g, logic [17:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_nar(logic [11:0] g, logic [11:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_cnt(int g, int e);
    checked++;
    if (g != e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [17:0] ref_y(int k);
    sfl_pkg::sfl_coef_set_type c = sfl_pkg::COEF_DEFAULT;
    int y;
    y = $signed(c.h1) * (hist[k+7] + hist[k]) + $signed(c.h2) * (hist[k+6] + hist[k+1])
      + $signed(c.h3) * (hist[k+5] + hist[k+2]) + $signed(c.h4) * (hist[k+4] + hist[k+3]);
    return 18'(y);
  endfunction
  // reset, stream hist through, compare every full-window result
  task automatic play();
    logic [17:0] e;
    rst = 1'b1;
    foreach (hist[i]) pm.src_q.push_back(7'(hist[i]));
    repeat (20) @(negedge core_clk);
    cmp_res(result, 18'h00000);
    cmp_nar(result_c, 12'h000);
    rst = 1'b0;
    lat = 0;
    while (result_valid !== 1'b1 && lat < 40) begin
      @(negedge core_clk);
      lat++;
    end
    repeat (hist.size()) @(negedge core_clk);
    for (int k = 0; k + 7 < hist.size(); k++) begin
      cmp_res(pm.got_q[k], ref_y(k));
      e = ref_y(k);
      cmp_nar(got_c[k], e[17:6]);
    end
  endtask
  task automatic t_impulse();
    hist = {0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
    play();
    cmp_cnt(lat, sfl_pkg::TAP_COUNT + sfl_pkg::PIPE_LATENCY);
  endtask
  task automatic t_extremes();
    hist = {};
    repeat (10) hist.push_back(63);
    repeat (10) hist.push_back(-64);
    repeat (4) hist = {hist, 63, -64};
    play();
  endtask
  task automatic t_bit_walk();
    hist = {};
    for (int b = 0; b < 7; b++) hist = {hist, (b == 6) ? -64 : (1 << b), 0, 0, -1};
    play();
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    t_impulse();
    t_extremes();
    t_bit_walk();
    final_report();
  end
endmodule

/* bench/sfl_stream_partner.sv */
// upstream sample source and downstream result sink
`timescale 1ns/1ps
module sfl_stream_partner (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // stream
  output logic signed [6:0] sample_in,
  input wire logic signed [17:0] result,
  input wire logic result_valid
);
  logic signed [6:0] src_q[$];
  logic signed [17:0] got_q[$];
  bit took = 1'b0;
  initial sample_in = '0;
  // next sample after each taking edge, zeros once drained
  always @(negedge core_clk) begin
    if (took && src_q.size() > 0) void'(src_q.pop_front());
    sample_in = (src_q.size() > 0) ? src_q[0] : 7'sh00;
  end
  // note whether a queued sample was on offer out of reset at this edge, collect every valid result
  always @(posedge core_clk) begin
    took = !rst && src_q.size() > 0;
    if (rst) got_q = {};
    else if (result_valid) got_q.push_back(result);
  end
endmodule

/* inc/sfl_pkg.sv */
// shared constants and types of the symmetric lut-multiplier fir filter
package sfl_pkg;
  // filter shape
  localparam int TAP_COUNT = 8;
  localparam int FOLD_COUNT = 4;
  localparam int SAMPLE_W = 7;
  localparam int TAP_W = 8;
  localparam int COEF_W = 8;
  // table geometry: one address bit per folded tap
  localparam int LUT_ADDR_W = 4;
  localparam int LUT_DEPTH = 16;
  localparam int LUT_W = COEF_W + 2;
  // full-precision accumulator width
  localparam int ACC_W = LUT_W + TAP_W;
  // latency of the pipelined build, tap entry to result register
  localparam int PIPE_LATENCY = 5;
  localparam int COMB_LATENCY = 1;

  // the four folded coefficients, first coefficient in the low field
  typedef struct packed {
    logic signed [COEF_W-1:0] h4;
    logic signed [COEF_W-1:0] h3;
    logic signed [COEF_W-1:0] h2;
    logic signed [COEF_W-1:0] h1;
  } sfl_coef_set_type;

  // plain default coefficient set
  localparam sfl_coef_set_type COEF_DEFAULT = '{
    h4: 8'h40,
    h3: 8'h20,
    h2: 8'hF0,
    h1: 8'h08
  };
endpackage

/* src/sfl_fir.sv */
// parallel eight-tap symmetric fir filter built on a bit-slice lut vector multiplier
`timescale 1ns/1ps
module sfl_fir #(
  parameter sfl_pkg::sfl_coef_set_type COEFS = sfl_pkg::COEF_DEFAULT,
  parameter bit PIPELINED = 1'b1,
  parameter int OUT_W = sfl_pkg::ACC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sample stream from upstream, one per clock
  input wire logic signed [sfl_pkg::SAMPLE_W-1:0] sample_in,
  // result stream to downstream
  output logic signed [OUT_W-1:0] result,
  output logic result_valid
);
  localparam int SLICES = sfl_pkg::TAP_W;
  localparam int LEVELS = $clog2(SLICES);
  localparam int LATENCY = PIPELINED ? sfl_pkg::PIPE_LATENCY : sfl_pkg::COMB_LATENCY;
  localparam int FILL_W = $clog2(sfl_pkg::TAP_COUNT + 1);
  localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(sfl_pkg::TAP_COUNT);

  // tap registers, numbered from one as tap 1 .. tap 8
  logic signed [sfl_pkg::TAP_W-1:0] tap_q [1:sfl_pkg::TAP_COUNT];
  // folded taps, numbered from one
  logic signed [sfl_pkg::TAP_W-1:0] fold_d [1:sfl_pkg::FOLD_COUNT];
  logic signed [sfl_pkg::TAP_W-1:0] fold_q [1:sfl_pkg::FOLD_COUNT];
  logic signed [sfl_pkg::TAP_W-1:0] fold [1:sfl_pkg::FOLD_COUNT];
  // slice tables, slice 1 is the lsb slice
  logic [sfl_pkg::LUT_ADDR_W-1:0] slice_addr [1:SLICES];
  logic signed [sfl_pkg::LUT_W-1:0] slice_value [1:SLICES];
  // adder tree nodes, level 0 holds the extended slice values
  logic signed [sfl_pkg::ACC_W-1:0] node [0:LEVELS][0:SLICES-1];
  // final full-precision sum and output register for the unpipelined build
  logic signed [sfl_pkg::ACC_W-1:0] sum_full;
  logic signed [sfl_pkg::ACC_W-1:0] out_q;
  // fill tracking and valid delay line
  logic [FILL_W-1:0] fill_q;
  logic [LATENCY-1:0] valid_q;

  // sample shift register, new sample into tap 1
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int t = 1; t <= sfl_pkg::TAP_COUNT; t++) begin
        tap_q[t] <= '0;
      end
    end else begin
      // sign extension leaves room for the fold carry
      tap_q[1] <= sfl_pkg::TAP_W'(sample_in);
      for (int t = 2; t <= sfl_pkg::TAP_COUNT; t++) begin
        tap_q[t] <= tap_q[t-1];
      end
    end
  end

  // mirror-tap adders: tap k pairs with tap 9-k
  always_comb begin
    for (int k = 1; k <= sfl_pkg::FOLD_COUNT; k++) begin
      fold_d[k] = tap_q[k] + tap_q[sfl_pkg::TAP_COUNT + 1 - k];
    end
  end

  // fold adder register, used only in the pipelined build
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int k = 1; k <= sfl_pkg::FOLD_COUNT; k++) begin
        fold_q[k] <= '0;
      end
    end else begin
      for (int k = 1; k <= sfl_pkg::FOLD_COUNT; k++) begin
        fold_q[k] <= fold_d[k];
      end
    end
  end

  // select registered or direct folded taps
  always_comb begin
    for (int k = 1; k <= sfl_pkg::FOLD_COUNT; k++) begin
      fold[k] = PIPELINED ? fold_q[k] : fold_d[k];
    end
  end

  // one table per bit slice, all evaluated at once
  for (genvar b = 1; b <= SLICES; b++) begin : g_slice
    // address bit 0 comes from folded tap 1, bit 3 from folded tap 4
    assign slice_addr[b] = {fold[4][b-1], fold[3][b-1], fold[2][b-1], fold[1][b-1]};

    sfl_slice_lut #(
      .COEFS(COEFS),
      .NEGATE(b == SLICES),
      .REGISTERED(PIPELINED)
    ) u_lut (
      .core_clk(core_clk),
      .rst(rst),
      .addr(slice_addr[b]),
      .value(slice_value[b])
    );

    // sign-extend to the full accumulator width
    assign node[0][b-1] = sfl_pkg::ACC_W'(slice_value[b]);
  end

  // adder tree: upper input of each pair shifted by the slice spacing of its level
  for (genvar l = 1; l <= LEVELS; l++) begin : g_level
    localparam int SHIFT = 1 << (l - 1);
    for (genvar n = 0; n < (SLICES >> l); n++) begin : g_node
      logic signed [sfl_pkg::ACC_W-1:0] sum_d;
      logic signed [sfl_pkg::ACC_W-1:0] sum_q;

      // level 1 shifts by one place, each further level by double
      assign sum_d = node[l-1][2*n] + (node[l-1][2*n+1] <<< SHIFT);

      // adder output register
      always_ff @(posedge core_clk) begin
        if (rst) begin
          sum_q <= '0;
        end else begin
          sum_q <= sum_d;
        end
      end

      assign node[l][n] = PIPELINED ? sum_q : sum_d;
    end
    // unused upper nodes of this level
    for (genvar z = (SLICES >> l); z < SLICES; z++) begin : g_pad
      assign node[l][z] = '0;
    end
  end

  assign sum_full = node[LEVELS][0];

  // output register for the unpipelined build
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= sum_full;
    end
  end

  // a narrower output keeps the most significant bits
  always_comb begin
    if (PIPELINED) begin
      result = sum_full[sfl_pkg::ACC_W-1 -: OUT_W];
    end else begin
      result = out_q[sfl_pkg::ACC_W-1 -: OUT_W];
    end
  end

  // count samples until every tap holds a real sample
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fill_q <= '0;
    end else if (fill_q != FILL_FULL) begin
      fill_q <= fill_q + 1'b1;
    end
  end

  // valid follows full taps through the pipeline depth
  always_ff @(posedge core_clk) begin
    if (rst) begin
      valid_q <= '0;
    end else begin
      valid_q <= LATENCY'({valid_q, fill_q == FILL_FULL});
    end
  end

  assign result_valid = valid_q[LATENCY-1];
endmodule

/* src/sfl_slice_lut.sv */
// one bit-slice table: constant coefficient sums addressed by four folded-tap bits
`timescale 1ns/1ps
module sfl_slice_lut #(
  parameter sfl_pkg::sfl_coef_set_type COEFS = sfl_pkg::COEF_DEFAULT,
  parameter bit NEGATE = 1'b0,
  parameter bit REGISTERED = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // table address, bit 0 selects the first coefficient
  input wire logic [sfl_pkg::LUT_ADDR_W-1:0] addr,
  // selected sum
  output logic signed [sfl_pkg::LUT_W-1:0] value
);
  // entry = sum of coefficients whose address bit is set, negated for the sign slice
  function automatic logic signed [sfl_pkg::LUT_W-1:0] entry(input int a);
    logic signed [sfl_pkg::LUT_W-1:0] sum;
    sum = '0;
    if (a[0]) sum = sum + sfl_pkg::LUT_W'(COEFS.h1);
    if (a[1]) sum = sum + sfl_pkg::LUT_W'(COEFS.h2);
    if (a[2]) sum = sum + sfl_pkg::LUT_W'(COEFS.h3);
    if (a[3]) sum = sum + sfl_pkg::LUT_W'(COEFS.h4);
    if (NEGATE) sum = -sum;
    return sum;
  endfunction

  logic signed [sfl_pkg::LUT_W-1:0] rom [sfl_pkg::LUT_DEPTH];
  logic signed [sfl_pkg::LUT_W-1:0] value_q;

  // contents fixed at build time, no multiplier hardware
  for (genvar e = 0; e < sfl_pkg::LUT_DEPTH; e++) begin : g_rom
    assign rom[e] = entry(e);
  end

  // optional table output register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      value_q <= '0;
    end else begin
      value_q <= rom[addr];
    end
  end

  assign value = REGISTERED ? value_q : rom[addr];
endmodule
